// ### rtl/pirqb_bank.sv
// Peripheral interrupt flag and enable bank with an AHB-Lite register port.
// Assumes event strobes, flag levels and core controls all come from mclk logic.
//
// Behaviour
// RULE_01: Serial unit 2 done flag, bit 7, sets on completion, software clears.
// RULE_02: Serial unit 2 collision flag, bit 6, sets on master collision, software clears.
// RULE_03: UART2 receive flag, bit 5, read-only, follows full receive buffer.
// RULE_04: UART2 transmit flag, bit 4, read-only, follows empty transmit buffer.
// RULE_05: Timer 4 match flag, bit 3, sets on period match, software clears.
// RULE_06: Capture/compare 5,4,3 flags, bits 2..0, set on capture, software clears.
// RULE_07: In compare mode each capture/compare flag sets on match, software clears.
// RULE_08: A capture/compare unit in PWM mode does not drive its flag.
// RULE_09: All flags and enable bits reset to zero.
// RULE_10: Without priority scheme, peripheral group enable is also needed to forward.
// RULE_11: One enable bit per source across three enable registers.
// RULE_12: Enable register 1 covers the eight first-group sources.
// RULE_13: Enable register 2 covers second-group sources; bit 5 unimplemented.
// RULE_14: Unimplemented bits ignore writes and read zero.
// RULE_15: Enable register 3 mirrors the third flag register layout.
// RULE_16: Enable one lets its flag request; zero blocks it.
// RULE_17: Priority bits matter only while the priority scheme is enabled.
// RULE_18: Flags set regardless of any enable, so software can poll.
// RULE_19: Software should clear a flag before enabling and after servicing.
// RULE_20: Request output high when any flag and its enable are both set; the code also needs priority_scheme_enable or peripheral_group_enable.
`timescale 1ns/1ps

module pirqb_bank (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pirqb_pkg::pirqb_events_t events,
    input wire pirqb_pkg::pirqb_uart_t uart2_status,
    input wire logic [7:0] peripheral_flags_1,
    input wire logic [7:0] peripheral_flags_2,
    input wire logic [7:0] priority_1,
    input wire logic [7:0] priority_2,
    input wire logic [7:0] priority_3,
    input wire pirqb_pkg::pirqb_core_ctl_t core_ctl,
    output pirqb_pkg::pirqb_req_t req,
    output logic [7:0] peripheral_flags_3
);

    // Reset release synchroniser; assertion stays asynchronous
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Any flag with its enable set; shared by all three request terms
    function automatic logic any_pending(
        input logic [7:0] f1,
        input logic [7:0] f2,
        input logic [7:0] f3,
        input logic [7:0] e1,
        input logic [7:0] e2,
        input logic [7:0] e3
    );
        any_pending = |(f1 & e1) | |(f2 & e2) | |(f3 & e3);
    endfunction

    // Merge a bus write into a register through its write mask
    function automatic logic [7:0] masked_write(
        input logic [7:0] cur,
        input logic [7:0] wdata,
        input logic [7:0] wmask
    );
        masked_write = (cur & ~wmask) | (wdata & wmask);
    endfunction

    pirqb_pkg::pirqb_state_t st_q;
    pirqb_pkg::pirqb_state_t st_d;

    logic addr_phase;
    logic [7:0] hw_set;
    logic [7:0] cc_fire;
    logic [7:0] wdat8;
    logic [7:0] f2_impl;
    logic pend_all;
    logic pend_high;
    logic pend_low;
    logic forward_ok;

    assign addr_phase = hsel & hready & (htrans == pirqb_pkg::PIRQB_HTRANS_NONSEQ);
    assign wdat8 = hwdata[7:0];

    always_comb begin
        st_d = st_q;

        // Capture/compare strobes count only outside PWM mode
        cc_fire = 8'h00;
        cc_fire[pirqb_pkg::PIRQB_B_CAPCMP5:pirqb_pkg::PIRQB_B_CAPCMP3] =
            events.capcmp_event & ~events.capcmp_pwm; // see RULE_06 see RULE_07 see RULE_08

        // Hardware set terms; no enable is consulted here
        hw_set = cc_fire; // see RULE_18
        hw_set[pirqb_pkg::PIRQB_B_SERIAL2_DONE] = events.serial2_done; // see RULE_01
        hw_set[pirqb_pkg::PIRQB_B_SERIAL2_COLL] = events.serial2_collision; // see RULE_02
        hw_set[pirqb_pkg::PIRQB_B_TIMER4] = events.timer4_match; // see RULE_05

        // Data phase of a write lands one cycle after its address phase
        if (st_q.wr_pend) begin
            unique case (st_q.wr_addr)
                pirqb_pkg::PIRQB_OFF_FLAGS3: begin
                    st_d.peripheral_flags_3 = masked_write(st_q.peripheral_flags_3, wdat8,
                        pirqb_pkg::PIRQB_FLAGS3_WMASK);
                end
                pirqb_pkg::PIRQB_OFF_EN1: begin
                    st_d.peripheral_enables_1 = masked_write(st_q.peripheral_enables_1, wdat8,
                        pirqb_pkg::PIRQB_EN1_WMASK); // see RULE_12
                end
                pirqb_pkg::PIRQB_OFF_EN2: begin
                    st_d.peripheral_enables_2 = masked_write(st_q.peripheral_enables_2, wdat8,
                        pirqb_pkg::PIRQB_EN2_WMASK); // see RULE_13 see RULE_14
                end
                pirqb_pkg::PIRQB_OFF_EN3: begin
                    st_d.peripheral_enables_3 = masked_write(st_q.peripheral_enables_3, wdat8,
                        pirqb_pkg::PIRQB_EN3_WMASK); // see RULE_15 see RULE_11
                end
                default: begin
                    // Unmapped or read-only address: write dropped
                end
            endcase
        end

        // A set arriving with a software clear wins
        st_d.peripheral_flags_3 = st_d.peripheral_flags_3 | hw_set; // see RULE_01 see RULE_02 see RULE_05

        // Buffer status bits track the UART, so reading or writing the buffer clears them
        st_d.peripheral_flags_3[pirqb_pkg::PIRQB_B_UART2_RX] = uart2_status.uart2_rx_full; // see RULE_03
        st_d.peripheral_flags_3[pirqb_pkg::PIRQB_B_UART2_TX] = uart2_status.uart2_tx_empty; // see RULE_04

        // Unimplemented second-group bit never contributes
        f2_impl = peripheral_flags_2 & pirqb_pkg::PIRQB_EN2_WMASK; // see RULE_14

        // Requests judged on the state about to be registered
        pend_all = any_pending(peripheral_flags_1, f2_impl, st_d.peripheral_flags_3,
            st_d.peripheral_enables_1, st_d.peripheral_enables_2,
            st_d.peripheral_enables_3); // see RULE_16 see RULE_20
        pend_high = any_pending(peripheral_flags_1 & priority_1, f2_impl & priority_2,
            st_d.peripheral_flags_3 & priority_3, st_d.peripheral_enables_1,
            st_d.peripheral_enables_2, st_d.peripheral_enables_3);
        pend_low = any_pending(peripheral_flags_1 & ~priority_1, f2_impl & ~priority_2,
            st_d.peripheral_flags_3 & ~priority_3, st_d.peripheral_enables_1,
            st_d.peripheral_enables_2, st_d.peripheral_enables_3);

        // Group enable gates everything unless priority levels are on
        forward_ok = core_ctl.priority_scheme_enable | core_ctl.peripheral_group_enable; // see RULE_10

        st_d.req.periph_req = pend_all & forward_ok; // see RULE_10 see RULE_20
        // Priority split is only meaningful with the scheme enabled
        st_d.req.periph_req_high = pend_high & core_ctl.priority_scheme_enable; // see RULE_17
        st_d.req.periph_req_low = pend_low & core_ctl.priority_scheme_enable; // see RULE_17

        // Address phase: latch writes, and answer reads from post-update state
        // so a read right behind a write sees the written value.
        st_d.wr_pend = addr_phase & hwrite;
        st_d.wr_addr = haddr[7:0];
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                pirqb_pkg::PIRQB_OFF_FLAGS3: st_d.hrdata = {24'h000000, st_d.peripheral_flags_3};
                pirqb_pkg::PIRQB_OFF_EN1: st_d.hrdata = {24'h000000, st_d.peripheral_enables_1};
                pirqb_pkg::PIRQB_OFF_EN2: st_d.hrdata = {24'h000000, st_d.peripheral_enables_2};
                pirqb_pkg::PIRQB_OFF_EN3: st_d.hrdata = {24'h000000, st_d.peripheral_enables_3};
                pirqb_pkg::PIRQB_OFF_STATUS: st_d.hrdata = {29'h00000000, st_d.req};
                default: st_d.hrdata = 32'h00000000;
            endcase
        end else begin
            st_d.hrdata = 32'h00000000;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            st_q.peripheral_flags_3 <= pirqb_pkg::PIRQB_FLAGS3_RST; // see RULE_09
            st_q.peripheral_enables_1 <= pirqb_pkg::PIRQB_EN_RST; // see RULE_09
            st_q.peripheral_enables_2 <= pirqb_pkg::PIRQB_EN_RST;
            st_q.peripheral_enables_3 <= pirqb_pkg::PIRQB_EN_RST;
            st_q.wr_pend <= 1'b0;
            st_q.wr_addr <= 8'h00;
            st_q.hrdata <= 32'h00000000;
            st_q.req <= 3'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // Zero-wait slave: every transfer completes in one data-phase cycle
    assign hreadyout = 1'b1;
    assign hresp = pirqb_pkg::PIRQB_HRESP_OKAY;
    assign hrdata = st_q.hrdata;
    assign req = st_q.req;
    assign peripheral_flags_3 = st_q.peripheral_flags_3;

    // hsize unused: only whole-word transfers are expected
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8]};

endmodule // pirqb_bank

// ### inc/pirqb_pkg.sv
// Package for the peripheral interrupt flag and enable bank.
// Assumes a 32-bit AHB-Lite slave port and single-clock peripheral event sources.
package pirqb_pkg;

    // Register byte addresses on the bus
    localparam logic [7:0] PIRQB_OFF_FLAGS3 = 8'h00;
    localparam logic [7:0] PIRQB_OFF_EN1 = 8'h04;
    localparam logic [7:0] PIRQB_OFF_EN2 = 8'h08;
    localparam logic [7:0] PIRQB_OFF_EN3 = 8'h0c;
    localparam logic [7:0] PIRQB_OFF_STATUS = 8'h10;

    // Flag bit positions in peripheral_flags_3
    localparam int PIRQB_B_SERIAL2_DONE = 7;
    localparam int PIRQB_B_SERIAL2_COLL = 6;
    localparam int PIRQB_B_UART2_RX = 5;
    localparam int PIRQB_B_UART2_TX = 4;
    localparam int PIRQB_B_TIMER4 = 3;
    localparam int PIRQB_B_CAPCMP5 = 2;
    localparam int PIRQB_B_CAPCMP3 = 0;

    // Bits software may write; unimplemented and read-only bits stay out
    localparam logic [7:0] PIRQB_FLAGS3_WMASK = 8'hcf;
    localparam logic [7:0] PIRQB_EN1_WMASK = 8'hff;
    localparam logic [7:0] PIRQB_EN2_WMASK = 8'hdf;
    localparam logic [7:0] PIRQB_EN3_WMASK = 8'hff;

    // Power-on values
    localparam logic [7:0] PIRQB_FLAGS3_RST = 8'h00;
    localparam logic [7:0] PIRQB_EN_RST = 8'h00;

    // AHB-Lite encodings
    localparam logic [1:0] PIRQB_HTRANS_NONSEQ = 2'h2;
    localparam logic PIRQB_HRESP_OKAY = 1'h0;

    // Event strobes from the peripherals, one cycle each, plus the capture/compare PWM mode levels
    typedef struct packed {
        logic serial2_done;
        logic serial2_collision;
        logic timer4_match;
        logic [2:0] capcmp_event;
        logic [2:0] capcmp_pwm;
    } pirqb_events_t;

    // Level indications of the second UART buffers
    typedef struct packed {
        logic uart2_rx_full;
        logic uart2_tx_empty;
    } pirqb_uart_t;

    // Control levels from the core's interrupt logic
    typedef struct packed {
        logic peripheral_group_enable;
        logic priority_scheme_enable;
    } pirqb_core_ctl_t;

    // Requests handed to the core
    typedef struct packed {
        logic periph_req;
        logic periph_req_high;
        logic periph_req_low;
    } pirqb_req_t;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0] peripheral_flags_3;
        logic [7:0] peripheral_enables_1;
        logic [7:0] peripheral_enables_2;
        logic [7:0] peripheral_enables_3;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        pirqb_req_t req;
    } pirqb_state_t;

endpackage

// ### verif/pirqb_periph_model.sv
// Peripheral side model: event strobes and UART buffer levels.
// Assumes the bench holds each strobe command for one mclk cycle.
`timescale 1ns/1ps
module pirqb_periph_model (
    input wire logic mclk,
    input wire pirqb_pkg::pirqb_events_t ev_cmd,
    input wire pirqb_pkg::pirqb_uart_t uart_cmd,
    output pirqb_pkg::pirqb_events_t events,
    output pirqb_pkg::pirqb_uart_t uart2_status
);
    // Launched from mclk like a real peripheral, never mid-cycle
    always_ff @(posedge mclk) begin
        events <= ev_cmd;
        uart2_status <= uart_cmd;
    end
endmodule // pirqb_periph_model

// ### verif/pirqb_bank_monitor.sv
// Port checker for the peripheral interrupt bank.
// Assumes one mclk domain; bound onto pirqb_bank below.
`timescale 1ns/1ps
module pirqb_bank_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire pirqb_pkg::pirqb_events_t events,
    input wire pirqb_pkg::pirqb_uart_t uart2_status,
    input wire pirqb_pkg::pirqb_core_ctl_t core_ctl,
    input wire pirqb_pkg::pirqb_req_t req,
    input wire logic [7:0] peripheral_flags_3
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic wr_req;
    // A write taken here lands one edge later and may clear flags
    assign wr_req = hsel && hready && htrans == pirqb_pkg::PIRQB_HTRANS_NONSEQ && hwrite;
    chk_done_set: assert property (events.serial2_done |=> peripheral_flags_3[7])
        else $error("done flag not set");
    chk_coll_set: assert property (events.serial2_collision |=> peripheral_flags_3[6])
        else $error("collision flag not set");
    chk_rx_follow: assert property (1'b1 |=> peripheral_flags_3[5] == $past(uart2_status.uart2_rx_full))
        else $error("rx flag wrong");
    chk_tx_follow: assert property (1'b1 |=> peripheral_flags_3[4] == $past(uart2_status.uart2_tx_empty))
        else $error("tx flag wrong");
    chk_timer4_set: assert property (events.timer4_match |=> peripheral_flags_3[3])
        else $error("timer flag not set");
    chk_capcmp_set: assert property (events.capcmp_event[1] && !events.capcmp_pwm[1] |=> peripheral_flags_3[1])
        else $error("capcmp flag not set");
    chk_pwm_block: assert property (events.capcmp_pwm[2] && !peripheral_flags_3[2] && !$past(wr_req) |=> !peripheral_flags_3[2])
        else $error("pwm unit set its flag");
    chk_flag_hold: assert property (!$past(wr_req) |=> ($past(peripheral_flags_3) & ~peripheral_flags_3 & 8'hcf) == 8'h00)
        else $error("flag dropped without write");
    chk_reset_zero: assert property ($rose(rst_b) |-> peripheral_flags_3 == 8'h00 && !req.periph_req)
        else $error("not zero after reset");
    chk_group_gate: assert property (core_ctl == 2'h0 |=> !req.periph_req)
        else $error("request not gated");
    chk_bus_okay: assert property (hreadyout && hresp == pirqb_pkg::PIRQB_HRESP_OKAY && hrdata[31:8] == 24'h000000)
        else $error("bus response wrong");
    cov_req: cover property (!req.periph_req ##1 req.periph_req);
    cov_pwm: cover property (events.capcmp_pwm[2] && events.capcmp_event[2]);
    cov_rx: cover property ($rose(peripheral_flags_3[5]));
endmodule // pirqb_bank_monitor
bind pirqb_bank pirqb_bank_monitor pirqb_bank_monitor_i (.mclk, .rst_b, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .events, .uart2_status, .core_ctl, .req, .peripheral_flags_3);

// ### verif/tb_top.sv
// Bench for the peripheral interrupt bank over its AHB-Lite port.
// Assumes a one-cycle event strobe model on the peripheral side.
`timescale 1ns/1ps
module tb_top;
    logic mclk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] prio3, flags3;
    pirqb_pkg::pirqb_events_t ev_cmd, events;
    pirqb_pkg::pirqb_uart_t uart_cmd, uart2_status;
    pirqb_pkg::pirqb_core_ctl_t core_ctl;
    pirqb_pkg::pirqb_req_t req;
    int fails, check_count;
    pirqb_bank pirqb_bank_i (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .events, .uart2_status, .peripheral_flags_1(8'h00), .peripheral_flags_2(8'h00),
        .priority_1(8'h00), .priority_2(8'h00), .priority_3(prio3), .core_ctl, .req, .peripheral_flags_3(flags3));
    pirqb_periph_model pirqb_periph_model_i (.mclk, .ev_cmd, .uart_cmd, .events, .uart2_status);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task test_done;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            fails++;
            test_done;
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= pirqb_pkg::PIRQB_HTRANS_NONSEQ;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h00000000);
        cmp(what, exp, rd);
    endtask
    // Event word is {done, collision, timer4, capcmp_event[2:0], capcmp_pwm[2:0]}; PWM levels stay on
    task pulse(input logic [8:0] e);
        ev_cmd <= e;
        @(posedge mclk);
        ev_cmd <= {6'h00, e[2:0]};
        repeat (2) @(posedge mclk);
    endtask
    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata, prio3, ev_cmd, uart_cmd, core_ctl} = '0;
        hsize = 3'h2;
        fails = 0;
        check_count = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'(4 * i), 32'h0, "reset value");
        end
        $display("Test reset done");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN1, 32'hff);
        rd_chk(pirqb_pkg::PIRQB_OFF_EN1, 32'hff, "enables_1");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN2, 32'hff);
        rd_chk(pirqb_pkg::PIRQB_OFF_EN2, 32'hdf, "enables_2");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN3, 32'hff);
        rd_chk(pirqb_pkg::PIRQB_OFF_EN3, 32'hff, "enables_3");
        xfer(1'b1, 8'h14, 32'hff);
        rd_chk(8'h14, 32'h0, "unmapped");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_FLAGS3, 32'hff);
        rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, 32'hcf, "flags_3 write");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h0);
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN3, 32'h0);
        rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h0, "flags_3 clear");
        $display("Test registers done");
        for (int i = 8; i >= 3; i--) begin
            pulse(9'h001 << i);
            rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, (i > 6) ? (32'h1 << (i - 1)) : (i == 6) ? 32'h8 : (32'h1 << (i - 3)),
                "event flag");
            xfer(1'b1, pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h0);
        end
        pulse(9'h03f);
        rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h0, "pwm flags");
        pulse(9'h000);
        uart_cmd <= 2'h3;
        repeat (3) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h30, "uart flags set");
        uart_cmd <= 2'h0;
        repeat (3) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_FLAGS3, 32'h0, "uart flags clear");
        $display("Test events done");
        pulse(9'h040);
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN3, 32'h08);
        repeat (2) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_STATUS, 32'h0, "request gated");
        core_ctl <= 2'h2;
        repeat (2) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_STATUS, 32'h4, "request group");
        prio3 <= 8'h08;
        core_ctl <= 2'h1;
        repeat (2) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_STATUS, 32'h6, "request high");
        prio3 <= 8'h00;
        repeat (2) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_STATUS, 32'h5, "request low");
        xfer(1'b1, pirqb_pkg::PIRQB_OFF_EN3, 32'h0);
        repeat (2) @(posedge mclk);
        rd_chk(pirqb_pkg::PIRQB_OFF_STATUS, 32'h0, "request masked");
        $display("Test request done");
        test_done;
    end
endmodule // tb_top
